// *** logic/sec_pkg.sv ***
// Purpose: constants and types of the serial eeprom command controller
// Assumes: pclk at 250 MHz, apb with 32-bit data, 128x8 three-wire eeprom
// Notes: register offsets are byte addresses
// Notes on behaviour
// (RQ1) host waits for the boot address load to end before its own commands
// (RQ2) host loads the data register before a write or write-all
// (RQ3) host sets the location field together with the write command code
// (RQ4) host setting busy starts a command; device clears busy when done
// (RQ5) read places the eeprom byte in the data register before busy clears
// (RQ6) host leaves the command register alone while busy is set
// (RQ7) no eeprom answer within 30 ms abandons the command, sets timeout flag
// (RQ8) erase-location erases the addressed byte; 30 ms timeout applies
// (RQ9) erase-all erases every byte; 30 ms timeout applies
// (RQ10) after erase/write disable the eeprom ignores erase and write
// (RQ11) host enables erase/write before any change; eeprom powers up disabled
// (RQ12) write-location stores the data register at the location field
// (RQ13) write-all stores the data register in every location
// (RQ14) frames take 10 serial clocks, or 18 for read, write and write-all
// (RQ15) reload fails unless location zero holds A5; success sets loaded flag
// (RQ16) interface disabled: pins become general outputs or internal monitors
// (RQ17) address load copies locations one to six into station bytes 0 to 5
// (RQ18) eeprom holds 128 bytes, so locations are seven bits
// (RQ19) frame: select, start bit, two-bit opcode, seven-bit address, data
package sec_pkg;
  // timing
  localparam int CLK_NS        = 4;
  localparam int SCK_PERIOD_NS = 1000;
  localparam int SCK_HALF_CYC  = (SCK_PERIOD_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int TMO_MS        = 30;
  localparam int TMO_CYC       = TMO_MS * 1000000 / CLK_NS;
  localparam int SYNC_LAT      = 3; // pin register plus two synchroniser flops
  // frame shape
  localparam logic [4:0] BITS_SHORT = 5'd10;
  localparam logic [4:0] BITS_LONG  = 5'd18;
  localparam int         LOC_W      = 7;
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [1:0] OP_ERASE   = 2'h3;
  localparam logic [1:0] OP_EXT     = 2'h0;
  localparam logic [1:0] EXT_ERASE_WRITE_DISABLE_CMD   = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL_CMD   = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL_CMD   = 2'h2;
  localparam logic [1:0] EXT_ERASE_WRITE_ENABLE_CMD   = 2'h3;
  localparam logic [7:0] SIG_BYTE   = 8'hA5;
  localparam logic [2:0] STN_LAST   = 3'h5;
  // register map
  localparam logic [7:0] ADDR_CMD   = 8'h00;
  localparam logic [7:0] ADDR_DATA  = 8'h04;
  localparam logic [7:0] ADDR_STNLO = 8'h08;
  localparam logic [7:0] ADDR_STNHI = 8'h0C;
  localparam logic [7:0] ADDR_ISTS  = 8'h10;
  localparam logic [7:0] ADDR_IMSK  = 8'h14;
  localparam logic [7:0] ADDR_PCFG  = 8'h18;
  localparam int CMD_BSY  = 31;
  localparam int CMD_CODE = 28;
  localparam int CMD_TO   = 9;
  localparam int CMD_LD   = 8;
  localparam int INT_DONE = 0;
  localparam int INT_TMO  = 1;
  localparam int INT_LOAD = 2;
  localparam int INT_W    = 3;
  localparam int PC_DIS   = 0;
  localparam int PC_MON   = 1;
  localparam int PC_GPD   = 2;
  localparam int PC_GPC   = 3;
  localparam int PC_W     = 4;
  typedef enum logic [2:0] {
    CMD_READ, CMD_ERASE_WRITE_DISABLE_CMD, CMD_ERASE_WRITE_ENABLE_CMD, CMD_WRITE, CMD_WRITE_ALL_CMD, CMD_ERASE, CMD_ERASE_ALL_CMD, CMD_RELOAD
  } sec_cmd_t;
  typedef struct packed {
    logic [17:0] frame;
    logic [4:0]  nbits;
    logic [4:0]  drive;
    logic        wait_rdy;
  } sec_job_t;
  typedef struct packed {
    logic sclk;
    logic cs;
    logic dout;
    logic doe_n;
  } sec_pins_t;
endpackage

// *** logic/sec_shift.sv ***
// Purpose: serial frame engine for a three-wire eeprom
// Assumes: one job at a time, start only while idle
// Notes: serial clock made here by a divider; data input synchronised
`timescale 1ns/1ps
`default_nettype none
module sec_shift #(
  parameter int HALF = sec_pkg::SCK_HALF_CYC,
  parameter int TMO  = sec_pkg::TMO_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              start,
  input  wire sec_pkg::sec_job_t job,
  input  wire logic              di_pin,
  output var  sec_pkg::sec_pins_t pins,
  output var  logic [7:0]        rdata,
  output var  logic              done,
  output var  logic              tmo
);
  import sec_pkg::*;
  localparam int DW = $clog2(HALF + 1);
  localparam int TW = $clog2(TMO + 1);
  typedef enum logic [1:0] {SH_IDLE, SH_SHIFT, SH_GAP, SH_WAIT} sec_sh_t;
  generate
    if (HALF <= SYNC_LAT || TMO <= SYNC_LAT)
    begin : g_bad
      $error("sec_shift: divider or timeout too small");
    end
  endgenerate

  sec_sh_t       st_ff;
  sec_sh_t       nxt_st;
  sec_job_t      job_ff;
  logic [DW-1:0] div_ff;
  logic [TW-1:0] tmo_ff;
  logic [17:0]   sh_ff;
  logic [4:0]    cnt_ff;
  logic [4:0]    rise_ff;
  logic          sclk_ff;
  logic          di_m_ff;
  logic          di_ff;
  logic [7:0]    rd_ff;
  wire           tick    = (div_ff == DW'(HALF - 1));
  wire           last    = (cnt_ff == job_ff.nbits - 5'd1);
  wire           tmo_hit = (tmo_ff == TW'(TMO - 1));
  // the released line is stale until select has reached the part and come back through the synchroniser
  wire           rdy     = di_ff && (tmo_ff >= TW'(SYNC_LAT));

  // state walk: shift the frame, drop select, then poll for ready if the job sets wait_rdy
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      SH_IDLE:  if (start) nxt_st = SH_SHIFT;
      SH_SHIFT: if (tick && sclk_ff && last) nxt_st = SH_GAP;
      SH_GAP:   if (tick) nxt_st = job_ff.wait_rdy ? SH_WAIT : SH_IDLE;
      SH_WAIT:  if (rdy || tmo_hit) nxt_st = SH_IDLE;
      default:  nxt_st = SH_IDLE;
    endcase
  end

  assign done  = (st_ff == SH_GAP && tick && !job_ff.wait_rdy) ||
                 (st_ff == SH_WAIT && (rdy || tmo_hit));
  assign tmo   = (st_ff == SH_WAIT) && !rdy && tmo_hit; // RQ7
  assign rdata = rd_ff;
  assign pins.sclk  = sclk_ff;
  assign pins.cs    = (st_ff == SH_SHIFT) || (st_ff == SH_WAIT); // RQ19
  assign pins.dout  = sh_ff[17];
  assign pins.doe_n = !((st_ff == SH_SHIFT) && (cnt_ff < job_ff.drive));

  // two-flop synchroniser for the eeprom data pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      di_m_ff <= 1'b0;
      di_ff   <= 1'b0;
    end
    else
    begin
      di_m_ff <= di_pin;
      di_ff   <= di_m_ff;
    end
  end

  // divider and ready-wait counter run only while busy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff  <= SH_IDLE;
      div_ff <= '0;
      tmo_ff <= '0;
    end
    else
    begin
      st_ff  <= nxt_st;
      div_ff <= (st_ff == SH_IDLE || tick) ? '0 : div_ff + DW'(1);
      tmo_ff <= (st_ff == SH_WAIT) ? tmo_ff + TW'(1) : '0;
    end
  end

  // sample on the rising serial edge, advance on the falling one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      job_ff  <= '0;
      sh_ff   <= '0;
      cnt_ff  <= '0;
      rise_ff <= '0;
      sclk_ff <= 1'b0;
      rd_ff   <= '0;
    end
    else if (st_ff == SH_IDLE && start)
    begin
      job_ff  <= job;
      sh_ff   <= job.frame;
      cnt_ff  <= '0;
      rise_ff <= '0;
      sclk_ff <= 1'b0;
    end
    else if (st_ff == SH_SHIFT && tick)
    begin
      sclk_ff <= !sclk_ff;
      if (!sclk_ff)
      begin
        rd_ff   <= {rd_ff[6:0], di_ff};
        rise_ff <= rise_ff + 5'd1;
      end
      else
      begin
        sh_ff  <= {sh_ff[16:0], 1'b0};
        cnt_ff <= cnt_ff + 5'd1;
      end
    end
  end

  a_clock_count: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
    (st_ff == SH_SHIFT && nxt_st == SH_GAP) |=> rise_ff == job_ff.nbits)
    else $error("serial clock count differs from frame length");
  a_wait_bound: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    tmo |=> st_ff == SH_IDLE && !pins.cs)
    else $error("wait for ready not abandoned on timeout");
endmodule
`default_nettype wire

// *** logic/sec_ctrl.sv ***
// Purpose: apb command and data registers driving a three-wire eeprom
// Assumes: pclk at 250 MHz; mii_mon comes from logic on pclk
// Notes: boot address load runs after reset with busy set
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sec_ctrl #(
  parameter int TMO_CYCLES = sec_pkg::TMO_CYC,
  parameter int HALF       = sec_pkg::SCK_HALF_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        irq,
  output var  logic        serial_clock_pin,
  output var  logic        chip_select_pin,
  output var  logic        serial_data_out,
  output var  logic        serial_data_oe_n,
  input  wire logic        serial_data_in,
  input  wire logic [1:0]  mii_mon,
  output var  logic [47:0] station_address
);
  import sec_pkg::*;
  typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_OP, ST_SIG, ST_LOAD} sec_st_t;

  // frame builder shared by host commands and address loading
  function automatic sec_job_t mk_job(sec_cmd_t c, logic [LOC_W-1:0] a, logic [7:0] d);
    sec_job_t j;
    j = '{frame: {1'b1, OP_EXT, EXT_ERASE_WRITE_DISABLE_CMD, 5'h00, 8'h00},
          nbits: BITS_SHORT, drive: BITS_SHORT, wait_rdy: 1'b0};
    case (c)
      CMD_READ:
      begin
        j.frame = {1'b1, OP_READ, a, 8'h00};
        j.nbits = BITS_LONG; // RQ14
      end
      CMD_ERASE_WRITE_ENABLE_CMD:  j.frame = {1'b1, OP_EXT, EXT_ERASE_WRITE_ENABLE_CMD, 5'h00, 8'h00};
      CMD_WRITE: j = '{{1'b1, OP_WRITE, a, d}, BITS_LONG, BITS_LONG, 1'b1};
      CMD_WRITE_ALL_CMD:  j = '{{1'b1, OP_EXT, EXT_WRITE_ALL_CMD, 5'h00, d}, BITS_LONG, BITS_LONG, 1'b1};
      CMD_ERASE: j = '{{1'b1, OP_ERASE, a, 8'h00}, BITS_SHORT, BITS_SHORT, 1'b1};
      CMD_ERASE_ALL_CMD:  j = '{{1'b1, OP_EXT, EXT_ERASE_ALL_CMD, 5'h00, 8'h00}, BITS_SHORT, BITS_SHORT, 1'b1};
      default:   j.nbits = BITS_SHORT;
    endcase
    return j;
  endfunction

  function automatic logic known(logic [7:0] a);
    return a == ADDR_CMD || a == ADDR_DATA || a == ADDR_STNLO || a == ADDR_STNHI ||
           a == ADDR_ISTS || a == ADDR_IMSK || a == ADDR_PCFG;
  endfunction

  sec_st_t          st_ff;
  logic             busy_ff;
  sec_cmd_t         code_ff;
  logic [LOC_W-1:0] loc_ff;
  logic             to_ff;
  logic             ld_ff;
  logic [7:0]       data_ff;
  logic [47:0]      stn_ff;
  logic [2:0]       idx_ff;
  logic [INT_W-1:0] sts_ff;
  logic [INT_W-1:0] msk_ff;
  logic [PC_W-1:0]  pcfg_ff;
  logic             start_ff;
  sec_job_t         job_ff;
  logic [31:0]      prdata_ff;
  logic             pready_ff;
  logic             pslverr_ff;
  logic             irq_ff;
  sec_pins_t        pin_ff;
  sec_pins_t        eng_pins;
  logic [7:0]       eng_rd;
  logic             eng_done;
  logic             eng_tmo;

  sec_shift #(.HALF(HALF), .TMO(TMO_CYCLES)) u_shift (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (start_ff),
    .job     (job_ff),
    .di_pin  (serial_data_in),
    .pins    (eng_pins),
    .rdata   (eng_rd),
    .done    (eng_done),
    .tmo     (eng_tmo)
  );

  // apb decode; access phase always completes in one cycle
  wire       setup    = psel && !penable;
  wire       wr_acc   = psel && penable && pwrite && pready_ff;
  wire       wr_cmd   = wr_acc && paddr == ADDR_CMD;
  wire       wr_data  = wr_acc && paddr == ADDR_DATA && !busy_ff;
  wire       wr_lo    = wr_acc && paddr == ADDR_STNLO && !busy_ff;
  wire       wr_hi    = wr_acc && paddr == ADDR_STNHI && !busy_ff;
  wire       wr_ists  = wr_acc && paddr == ADDR_ISTS;
  wire       wr_imsk  = wr_acc && paddr == ADDR_IMSK;
  wire       wr_pcfg  = wr_acc && paddr == ADDR_PCFG;
  // busy commands ignore command writes; the host must wait anyway
  wire       host_go  = wr_cmd && !busy_ff && pwdata[CMD_BSY]; // RQ4
  wire       to_clr   = wr_cmd && !busy_ff && pwdata[CMD_TO];
  wire       sig_ok   = eng_rd == SIG_BYTE;
  wire       op_end   = st_ff == ST_OP && eng_done;
  wire       sig_end  = st_ff == ST_SIG && eng_done;
  wire       ld_end   = st_ff == ST_LOAD && eng_done;
  wire       ld_last  = ld_end && idx_ff == STN_LAST;
  wire       fin      = op_end || (sig_end && !sig_ok) || ld_last; // RQ4
  sec_cmd_t  host_code;
  assign host_code = sec_cmd_t'(pwdata[CMD_CODE +: 3]);

  // read mux
  wire [31:0] cmd_word = (32'(busy_ff) << CMD_BSY) | (32'(code_ff) << CMD_CODE) |
                         (32'(to_ff) << CMD_TO) | (32'(ld_ff) << CMD_LD) | 32'(loc_ff);
  wire [31:0] rd_word  = paddr == ADDR_CMD   ? cmd_word :
                         paddr == ADDR_DATA  ? 32'(data_ff) :
                         paddr == ADDR_STNLO ? stn_ff[31:0] :
                         paddr == ADDR_STNHI ? 32'(stn_ff[47:32]) :
                         paddr == ADDR_ISTS  ? 32'(sts_ff) :
                         paddr == ADDR_IMSK  ? 32'(msk_ff) :
                         paddr == ADDR_PCFG  ? 32'(pcfg_ff) : 32'h0000_0000;

  // interrupt events; a set in the clearing cycle wins
  wire [INT_W-1:0] ev  = (INT_W'(fin) << INT_DONE) | (INT_W'(op_end && eng_tmo) << INT_TMO) |
                         (INT_W'(ld_last) << INT_LOAD);
  wire [INT_W-1:0] w1c = wr_ists ? pwdata[INT_W-1:0] : '0;

  // pins: engine, or general outputs and monitors when disabled
  wire       if_off  = pcfg_ff[PC_DIS];
  wire       mon     = pcfg_ff[PC_MON];
  sec_pins_t nxt_pin;
  assign nxt_pin.sclk  = if_off ? (mon ? mii_mon[1] : pcfg_ff[PC_GPC]) : eng_pins.sclk; // RQ16
  assign nxt_pin.dout  = if_off ? (mon ? mii_mon[0] : pcfg_ff[PC_GPD]) : eng_pins.dout; // RQ16
  assign nxt_pin.cs    = !if_off && eng_pins.cs;
  assign nxt_pin.doe_n = if_off ? 1'b0 : eng_pins.doe_n;

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff  <= '0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !known(paddr);
      if (setup)
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_word;
    end
  end

  // sequencer: host command, or signature check then six byte reads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff    <= ST_BOOT;
      start_ff <= 1'b0;
      job_ff   <= '0;
      idx_ff   <= '0;
    end
    else
    begin
      start_ff <= 1'b0;
      case (st_ff)
        ST_BOOT:
        begin
          start_ff <= 1'b1; // RQ17
          job_ff   <= mk_job(CMD_READ, '0, '0);
          st_ff    <= ST_SIG;
        end
        ST_IDLE:
          if (host_go)
          begin
            start_ff <= 1'b1;
            job_ff   <= mk_job(host_code, pwdata[LOC_W-1:0], data_ff); // RQ12 RQ13 RQ8 RQ9
            st_ff    <= host_code == CMD_RELOAD ? ST_SIG : ST_OP;
            if (host_code == CMD_RELOAD)
              job_ff <= mk_job(CMD_READ, '0, '0); // RQ15
          end
        ST_OP:
          if (eng_done)
            st_ff <= ST_IDLE;
        ST_SIG:
          if (eng_done)
          begin
            idx_ff   <= '0;
            start_ff <= sig_ok; // RQ15
            job_ff   <= mk_job(CMD_READ, LOC_W'(1), '0);
            st_ff    <= sig_ok ? ST_LOAD : ST_IDLE;
          end
        ST_LOAD:
          if (eng_done)
          begin
            idx_ff   <= idx_ff + 3'd1;
            start_ff <= !ld_last;
            job_ff   <= mk_job(CMD_READ, LOC_W'(idx_ff) + LOC_W'(2), '0); // RQ17 RQ18
            st_ff    <= ld_last ? ST_IDLE : ST_LOAD;
          end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // command register fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_ff <= 1'b1;
      code_ff <= CMD_READ;
      loc_ff  <= '0;
      to_ff   <= 1'b0;
      ld_ff   <= 1'b0;
    end
    else
    begin
      if (host_go)
      begin
        code_ff <= host_code;
        loc_ff  <= pwdata[LOC_W-1:0]; // RQ18
      end
      busy_ff <= fin ? 1'b0 : (busy_ff || host_go); // RQ4
      to_ff   <= (op_end && eng_tmo) || (to_ff && !to_clr && !host_go); // RQ7
      ld_ff   <= ld_last || (ld_ff && !(host_go && host_code == CMD_RELOAD)); // RQ15
    end
  end

  // data register, station address, status, mask and pin setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_ff <= '0;
      stn_ff  <= '0;
      sts_ff  <= '0;
      msk_ff  <= '0;
      pcfg_ff <= '0;
      irq_ff  <= 1'b0;
      pin_ff  <= '{sclk: 1'b0, cs: 1'b0, dout: 1'b0, doe_n: 1'b1};
    end
    else
    begin
      if (op_end && code_ff == CMD_READ)
        data_ff <= eng_rd; // RQ5
      else if (wr_data)
        data_ff <= pwdata[7:0];
      if (ld_end)
        stn_ff[8*idx_ff +: 8] <= eng_rd; // RQ17
      else if (wr_lo)
        stn_ff[31:0] <= pwdata;
      else if (wr_hi)
        stn_ff[47:32] <= pwdata[15:0];
      sts_ff <= (sts_ff & ~w1c) | ev;
      if (wr_imsk)
        msk_ff <= pwdata[INT_W-1:0];
      if (wr_pcfg)
        pcfg_ff <= pwdata[PC_W-1:0];
      irq_ff <= |(sts_ff & msk_ff);
      pin_ff <= nxt_pin;
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign irq              = irq_ff;
  assign serial_clock_pin = pin_ff.sclk;
  assign chip_select_pin  = pin_ff.cs;
  assign serial_data_out  = pin_ff.dout;
  assign serial_data_oe_n = pin_ff.doe_n;
  assign station_address  = stn_ff;

  a_busy_clear: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    $fell(busy_ff) |-> $past(eng_done) && $past(st_ff) != ST_IDLE)
    else $error("busy fell without a finished operation");
  a_busy_start: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    host_go |=> busy_ff ##1 eng_pins.cs)
    else $error("command start did not raise busy and run the engine");
  a_read_data: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    (op_end && code_ff == CMD_READ) |=> data_ff == $past(eng_rd) && !busy_ff)
    else $error("read result not in data register");
  a_tmo_flag: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    (op_end && eng_tmo) |=> to_ff && sts_ff[INT_TMO])
    else $error("timeout flag not set");
  a_reload_fail: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
    (sig_end && !sig_ok) |=> !ld_ff && !busy_ff && st_ff == ST_IDLE)
    else $error("reload without signature not failed");
  a_load_flag: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
    ld_last |=> ld_ff && stn_ff[47:40] == $past(eng_rd))
    else $error("last station byte or loaded flag wrong");
  a_pin_general: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
    (if_off && !mon) |=> serial_clock_pin == $past(pcfg_ff[PC_GPC]) && !chip_select_pin)
    else $error("disabled interface pins not general outputs");
  a_frame_start: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
    start_ff |-> job_ff.frame[17] && (job_ff.nbits == BITS_SHORT || job_ff.nbits == BITS_LONG))
    else $error("frame lacks start bit or length");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == $past(|(sts_ff & msk_ff)))
    else $error("interrupt output does not follow status and mask");
  c_write: cover property (@(posedge pclk) disable iff (!presetn)
    op_end && code_ff == CMD_WRITE && !eng_tmo);
  c_timeout: cover property (@(posedge pclk) disable iff (!presetn) op_end && eng_tmo);
  c_load: cover property (@(posedge pclk) disable iff (!presetn) ld_last);
  c_no_sig: cover property (@(posedge pclk) disable iff (!presetn) sig_end && !sig_ok);
endmodule
`default_nettype wire

// *** tb/sec_eeprom_model.sv ***
// Purpose: behavioural three-wire eeprom of 128 bytes facing the controller
// Assumes: frame bits MSB first, taken on the rising serial clock
// Notes: mute keeps the ready line low so that the controller times out
`timescale 1ns/1ps
`default_nettype none
module sec_eeprom_model (
  input  wire logic pclk,
  input  wire logic sclk,
  input  wire logic cs,
  input  wire logic din,
  input  wire logic mute,
  output wire logic dout
);
  logic [7:0]  mem [128];
  logic [17:0] sr;
  logic [1:0]  op;
  logic [6:0]  a;
  logic [7:0]  d;
  logic [6:0]  ra;
  logic        en = 1'b0;
  logic        rd_on = 1'b0;
  logic        rd_bit = 1'b0;
  logic        junk = 1'b0;
  int          cnt = 0;
  int          prog = 0;
  // frame shifted in on the rising serial clock
  always @(posedge sclk)
    if (cs)
    begin
      sr = {sr[16:0], din};
      cnt = cnt + 1;
    end
  always @(posedge cs)
  begin
    cnt = 0;
    rd_on = 1'b0;
  end
  // read data goes out on falling edges after the address
  always @(negedge sclk)
  begin
    if (cs && cnt == 10 && sr[9:7] == 3'b110)
    begin
      rd_on = 1'b1;
      ra = sr[6:0];
    end
    if (rd_on && cnt >= 10 && cnt < 18)
      rd_bit = mem[ra][17 - cnt];
  end
  // act when select drops; a disabled or mute part changes no stored byte
  always @(negedge cs)
  begin
    {op, a, d} = (cnt == 18) ? sr[16:0] : {sr[8:0], 8'h00};
    if ((cnt == 10 && sr[9]) || (cnt == 18 && sr[17]))
    begin
      if (cnt == 10 && op == 2'b00 && a[6:5] != 2'b10)
        en = a[6:5] == 2'b11;
      if (en && !mute && cnt == 10 && op == 2'b11)
        mem[a] = 8'hFF;
      if (en && !mute && cnt == 10 && op == 2'b00 && a[6:5] == 2'b10)
        mem = '{default: 8'hFF};
      if (en && !mute && cnt == 18 && op == 2'b01)
        mem[a] = d;
      if (en && !mute && cnt == 18 && op == 2'b00 && a[6:5] == 2'b01)
        mem = '{default: d};
      prog = 40;
    end
  end
  // released line shows a changing pattern, never the last value
  always @(posedge pclk)
  begin
    junk = ~junk;
    if (prog > 0)
      prog = prog - 1;
  end
  assign dout = !cs ? junk : rd_on ? rd_bit : (cnt == 0) ? (prog == 0 && !mute) : junk;
endmodule
`default_nettype wire

// *** tb/serial_eeprom_command_ctrl_tb.sv ***
// Purpose: self-checking bench of the eeprom command controller over apb
// Assumes: short serial half period and timeout set by parameters
// Notes: a byte array with an enable flag models the eeprom contents
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_command_ctrl_tb;
  import sec_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, irq, sck, csel, sdo, sdo_oe_n, sdi, rerr, mute = 1'b0, ref_en = 1'b0;
  logic [1:0]  mii_mon = 2'h0;
  logic [47:0] stn;
  logic [7:0]  ref_mem [128];
  logic [7:0]  d;
  logic [6:0]  loc;
  logic [2:0]  code;
  logic [2:0]  seq [10] = '{3'h3, 3'h2, 3'h3, 3'h5, 3'h4, 3'h6, 3'h3, 3'h3, 3'h1, 3'h3};
  logic [15:0] rnd = 16'h0040;
  int          n_mismatch = 0, compares = 0, nclk = 0, frame_len = 0;
  always #2 pclk = ~pclk;
  sec_ctrl #(.TMO_CYCLES(200), .HALF(4)) sec_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .serial_clock_pin(sck), .chip_select_pin(csel), .serial_data_out(sdo),
    .serial_data_oe_n(sdo_oe_n), .serial_data_in(sdi), .mii_mon(mii_mon), .station_address(stn));
  sec_eeprom_model sec_eeprom_model_i (.pclk(pclk), .sclk(sck), .cs(csel), .din(sdo), .mute(mute), .dout(sdi));
  // serial clocks counted per frame; the ready poll has none
  always @(posedge sck) if (csel) nclk++;
  always @(posedge csel) nclk = 0;
  always @(negedge csel) if (nclk != 0) frame_len = nclk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic end_of_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; answer taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dw);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dw;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
    begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  // poll busy until it clears; rd keeps the last command word
  task automatic idle;
    int i;
    for (i = 0; i < 3000; i++)
    begin
      apb(1'b0, ADDR_CMD, 32'h0);
      if (rd[CMD_BSY] === 1'b0) break;
    end
    if (i == 3000)
    begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic cmd(input logic [2:0] c, input logic [6:0] l);
    frame_len = 0;
    apb(1'b1, ADDR_CMD, {1'b1, c, 21'h0, l});
    idle();
    if (c != 3'h7) chk("frame_len", frame_len, (c == 3'h0 || c == 3'h3 || c == 3'h4) ? 18 : 10);
  endtask
  initial
  begin
    for (int i = 0; i < 128; i++)
    begin
      rnd = lfsr(rnd);
      ref_mem[i] = (i == 0) ? 8'hA5 : rnd[7:0];
      sec_eeprom_model_i.mem[i] = ref_mem[i];
    end
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    idle();
    chk("loaded", rd[CMD_LD], 1'b1);
    chk("station", stn, {ref_mem[6], ref_mem[5], ref_mem[4], ref_mem[3], ref_mem[2], ref_mem[1]});
    // command table against the byte-array model, last write at the top location
    for (int k = 0; k < 10; k++)
    begin
      rnd = lfsr(rnd);
      code = seq[k];
      d = rnd[15:8];
      loc = (k == 7 || k == 9) ? 7'h7F : rnd[6:0];
      apb(1'b1, ADDR_DATA, {24'h0, d});
      cmd(code, loc);
      case (code)
        3'h1: ref_en = 1'b0;
        3'h2: ref_en = 1'b1;
        3'h3: if (ref_en) ref_mem[loc] = d;
        3'h4: if (ref_en) ref_mem = '{default: d};
        3'h5: if (ref_en) ref_mem[loc] = 8'hFF;
        3'h6: if (ref_en) ref_mem = '{default: 8'hFF};
        default: ;
      endcase
      cmd(3'h0, loc);
      apb(1'b0, ADDR_DATA, 32'h0);
      chk("read", rd, {24'h0, ref_mem[loc]});
    end
    cmd(3'h7, 7'h0);
    chk("reload", rd[CMD_LD], ref_mem[0] == 8'hA5);
    // silent part: write must be abandoned with the timeout flag
    cmd(3'h2, 7'h0);
    mute <= 1'b1;
    cmd(3'h3, 7'h05);
    chk("timeout", rd[CMD_TO], 1'b1);
    mute <= 1'b0;
    apb(1'b0, ADDR_ISTS, 32'h0);
    chk("ists_tmo", rd[INT_TMO], 1'b1);
    chk("irq_masked", irq, 1'b0);
    apb(1'b1, ADDR_IMSK, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq_on", irq, 1'b1);
    apb(1'b1, ADDR_ISTS, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq_off", irq, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {rerr, rd}, {1'b1, 32'h0});
    // interface off: pins follow monitor inputs or the general clock and data output bits
    apb(1'b1, ADDR_PCFG, 32'h3);
    for (int k = 1; k < 3; k++)
    begin
      mii_mon <= k[1:0];
      repeat (4) @(posedge pclk);
      chk("monitor", {sck, sdo}, {30'h0, k[1:0]});
    end
    apb(1'b1, ADDR_PCFG, 32'h9);
    repeat (4) @(posedge pclk);
    chk("gp_clock", {sck, sdo, sdo_oe_n, csel}, 4'h8);
    apb(1'b1, ADDR_PCFG, 32'h5);
    repeat (4) @(posedge pclk);
    chk("gp_data", {sck, sdo, sdo_oe_n, csel}, 4'h4);
    end_of_test();
  end
endmodule
`default_nettype wire
